// file: rtl/radar_host_regs.sv
// Purpose: Host-facing register bank, interrupt pin and measurement pacing
// Assumes: Requests and events come from logic on clk_sys
// Notes:   Answer to every request one cycle later; unmapped reads give err
`timescale 1ns/1ns
`default_nettype none

module radar_host_regs #(
    parameter logic [15:0] PART_CODE = 16'h5A01,    // Arbitrary value
    parameter logic [7:0]  FW_MAJOR  = 8'h01,
    parameter logic [7:0]  FW_MINOR  = 8'h00,
    parameter logic [7:0]  FW_PATCH  = 8'h00,
    parameter logic [31:0] TOP_BAUD  = 32'h000F_4240
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire radar_regs_pkg::reg_req_t req,
    input  wire radar_regs_pkg::events_t  evt,
    input  wire logic [31:0]              buf_count,
    input  wire logic                     meas_req,
    output var  radar_regs_pkg::reg_rsp_t rsp,
    output logic                          host_int,
    output logic                          meas_tick,
    output var  radar_regs_pkg::meas_cfg_t cfg,
    output logic [31:0]                   serial_baud
);
    import radar_regs_pkg::*;

    logic [31:0]       irq_en;
    logic [31:0]       irq_sel;
    logic [31:0]       pending;
    logic [31:0]       snap_count;
    logic [PACE_W-1:0] pace_acc;
    logic [31:0]       next_irq_en;
    logic [31:0]       next_irq_sel;
    logic [31:0]       next_pending;
    logic [31:0]       next_snap_count;
    logic [31:0]       next_baud;
    meas_cfg_t         next_cfg;
    reg_rsp_t          next_rsp;
    logic              next_host_int;
    logic [PACE_W-1:0] next_pace_acc;
    logic              next_tick;
    logic [31:0]       set_vec;
    logic              wr;
    logic              rd;

    ////////////////////////////////////////////////////////////////////////////////
    // Event vector at the enable-register bit positions; unused bits stay zero
    always_comb
    begin
        set_vec                  = ZERO_WORD;
        set_vec[BIT_CREATED]     = evt.created;       // see (R03)
        set_vec[BIT_ACTIVATED]   = evt.activated;     // see (R03)
        set_vec[BIT_DATA_READY]  = evt.data_ready;    // see (R04)
        set_vec[BIT_ERROR]       = evt.error;         // see (R05)
        set_vec[BIT_BAD_COMMAND] = evt.bad_command;   // see (R05)
        set_vec[BIT_BAD_MODE]    = evt.bad_mode;      // see (R05)
        set_vec[BIT_CREATE_FAIL] = evt.create_fail;   // see (R05)
    end

    // Request decode; every request is taken in the cycle that it stands
    assign wr = req.valid && req.write;
    assign rd = req.valid && !req.write;

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes, sticky pending bits and interrupt pin
    always_comb
    begin
        next_irq_en     = irq_en;
        next_irq_sel    = irq_sel;
        next_baud       = serial_baud;
        next_cfg        = cfg;
        next_snap_count = snap_count;
        next_pending    = pending;
        if (wr)
        begin
            unique case (req.addr)
                ADDR_IRQ_PENDING:  next_pending = pending & ~req.wdata;   // Write one to clear
                ADDR_SERIAL_BAUD:  next_baud = req.wdata;
                ADDR_IRQ_ENABLE:   next_irq_en = req.wdata;
                ADDR_IRQ_PIN_SEL:  next_irq_sel = req.wdata;
                ADDR_MODULE_SLEEP: next_cfg.module_sleep_config = req.wdata;
                ADDR_SWEEP_BEGIN:  next_cfg.sweep_begin_mm = req.wdata;   // see (R14)
                ADDR_SWEEP_SPAN:   next_cfg.sweep_span_mm = req.wdata;    // see (R14)
                ADDR_CADENCE_SRC:  next_cfg.cadence_source = req.wdata;
                ADDR_CADENCE_MHZ:  next_cfg.cadence_millihertz = req.wdata;   // see (R17)
                ADDR_RX_AMP:       next_cfg.rx_amplification =
                                       (req.wdata > GAIN_MAX) ? GAIN_MAX : req.wdata; // see (R18)
                ADDR_CHIP_SLEEP:   next_cfg.radar_chip_sleep_level =
                                       power_level_t'(req.wdata[POWER_W-1:0]);    // see (R19)
                default:           next_pending = pending;   // Read-only or unmapped: no effect; see (R08)
            endcase
        end
        // Events set pending even when disabled, and win over a clear
        next_pending = next_pending | set_vec;   // see (R20)
        // Metadata refreshed only on create or new data
        if (evt.created || evt.data_ready)
            next_snap_count = buf_count;   // see (R13) (R12)
        // Pin follows enabled pending sources in mode one only
        next_host_int = (irq_sel == PIN_SEL_ACTIVE) && |(pending & irq_en);   // see (R01) (R02) (R06) (R07)
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read answers
    always_comb
    begin
        next_rsp       = '0;
        next_rsp.valid = req.valid;
        if (rd)
        begin
            unique case (req.addr)
                ADDR_IRQ_PENDING:  next_rsp.rdata = pending;
                ADDR_SERIAL_BAUD:  next_rsp.rdata = serial_baud;
                ADDR_IRQ_ENABLE:   next_rsp.rdata = irq_en;
                ADDR_IRQ_PIN_SEL:  next_rsp.rdata = irq_sel;
                ADDR_MODULE_SLEEP: next_rsp.rdata = cfg.module_sleep_config;
                ADDR_PART_CODE:    next_rsp.rdata = {16'h0000, PART_CODE};   // see (R08)
                ADDR_FIRMWARE:     next_rsp.rdata = {8'h00, FW_MAJOR, FW_MINOR, FW_PATCH}; // see (R09)
                ADDR_TOP_SPEED:    next_rsp.rdata = TOP_BAUD;   // see (R10)
                ADDR_SWEEP_BEGIN:  next_rsp.rdata = cfg.sweep_begin_mm;
                ADDR_SWEEP_SPAN:   next_rsp.rdata = cfg.sweep_span_mm;
                ADDR_CADENCE_SRC:  next_rsp.rdata = cfg.cadence_source;
                ADDR_CADENCE_MHZ:  next_rsp.rdata = cfg.cadence_millihertz;
                ADDR_RX_AMP:       next_rsp.rdata = cfg.rx_amplification;
                ADDR_CHIP_SLEEP:   next_rsp.rdata = {30'h0, cfg.radar_chip_sleep_level};
                ADDR_PENDING_OUT:  next_rsp.rdata = snap_count;   // see (R12)
                default:           next_rsp.err = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Measurement pacing; rate accumulates once per clock in millihertz
    // A 32-bit rate stays far below the wrap, so at most one tick per clock.
    // In cap mode a request without full credit is dropped, not remembered:
    // the caller must hold its request until the tick appears.
    always_comb
    begin
        next_pace_acc = '0;
        next_tick     = 1'b0;
        if (cfg.cadence_source == CADENCE_SENSOR && cfg.cadence_millihertz != ZERO_WORD)
        begin
            // Exact long-run rate: wrap a phase accumulator
            next_pace_acc = pace_acc + PACE_W'(cfg.cadence_millihertz);   // see (R15) (R17)
            if (next_pace_acc >= PACE_WRAP)
            begin
                next_pace_acc = next_pace_acc - PACE_WRAP;
                next_tick     = 1'b1;
            end
        end
        else if (cfg.cadence_source == CADENCE_LIMIT)
        begin
            if (cfg.cadence_millihertz == ZERO_WORD)
                next_tick = meas_req;   // No cap; see (R16)
            else
            begin
                // Credit builds until one period has passed, then holds
                next_pace_acc = (pace_acc >= PACE_WRAP) ? pace_acc
                              : pace_acc + PACE_W'(cfg.cadence_millihertz);
                if (meas_req && pace_acc >= PACE_WRAP)
                begin
                    next_tick     = 1'b1;   // see (R16)
                    next_pace_acc = '0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            irq_en      <= ZERO_WORD;
            irq_sel     <= PIN_SEL_OFF;
            pending     <= ZERO_WORD;
            snap_count  <= ZERO_WORD;
            serial_baud <= DEFAULT_BAUD;   // see (R11)
            cfg         <= '0;
            rsp         <= '0;
            host_int    <= 1'b0;
            pace_acc    <= '0;
            meas_tick   <= 1'b0;
        end
        else
        begin
            irq_en      <= next_irq_en;
            irq_sel     <= next_irq_sel;
            pending     <= next_pending;
            snap_count  <= next_snap_count;
            serial_baud <= next_baud;
            cfg         <= next_cfg;
            rsp         <= next_rsp;
            host_int    <= next_host_int;
            pace_acc    <= next_pace_acc;
            meas_tick   <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks; the pin, pending bits and config each lag their cause by one cycle
    default clocking chk_clk @(posedge clk_sys); endclocking
    default disable iff (rst);

    pin_off_a: assert property (irq_sel == PIN_SEL_OFF |=> !host_int)   // see (R06)
        else $error("interrupt pin active in mode zero");
    pin_on_a: assert property ((irq_sel == PIN_SEL_ACTIVE && |(pending & irq_en)) |=> host_int) // see (R07)
        else $error("interrupt pin missed active source");
    mask_zero_a: assert property (irq_en == ZERO_WORD |=> !host_int)   // see (R02)
        else $error("interrupt with all enables clear");
    pin_cause_a: assert property (!(|(pending & irq_en)) |=> !host_int)   // see (R01)
        else $error("interrupt pin without enabled pending source");
    created_set_a: assert property (evt.created |=> pending[BIT_CREATED])   // see (R03)
        else $error("created event not recorded");
    error_set_a: assert property (evt.error |=> pending[BIT_ERROR])   // see (R05)
        else $error("error event not recorded");
    data_set_a: assert property (evt.data_ready |=> pending[BIT_DATA_READY])   // see (R04) (R20)
        else $error("data ready not recorded");
    fail_set_a: assert property (evt.create_fail |=> pending[BIT_CREATE_FAIL])   // see (R05)
        else $error("create failure not recorded");
    sticky_bit_a: assert property (pending[BIT_CREATED] && !wr |=> pending[BIT_CREATED]) // see (R20)
        else $error("pending bit lost without clear");
    pending_clear_a: assert property (wr && req.addr == ADDR_IRQ_PENDING   // see (R20)
                                      && req.wdata[BIT_DATA_READY] && !evt.data_ready
                                      |=> !pending[BIT_DATA_READY])
        else $error("pending bit not cleared by host");
    part_read_a: assert property (rd && req.addr == ADDR_PART_CODE   // see (R08)
                                  |=> rsp.valid && rsp.rdata[15:0] == PART_CODE)
        else $error("part code read wrong");
    snap_take_a: assert property ((evt.created || evt.data_ready)   // see (R12)
                                  |=> snap_count == $past(buf_count))
        else $error("buffer length not captured");
    snap_hold_a: assert property (!(evt.created || evt.data_ready)   // see (R13)
                                  |=> $stable(snap_count))
        else $error("buffer length changed without event");
    range_store_a: assert property (wr && req.addr == ADDR_SWEEP_BEGIN   // see (R14)
                                    |=> cfg.sweep_begin_mm == $past(req.wdata))
        else $error("range start not stored");
    gain_store_a: assert property (wr && req.addr == ADDR_RX_AMP   // see (R18)
                                   && req.wdata <= GAIN_MAX
                                   |=> cfg.rx_amplification == $past(req.wdata))
        else $error("gain in range not stored");
    power_store_a: assert property (wr && req.addr == ADDR_CHIP_SLEEP   // see (R19)
                                    |=> cfg.radar_chip_sleep_level
                                        == $past(req.wdata[POWER_W-1:0]))
        else $error("power level not stored");
    gain_cap_a: assert property (cfg.rx_amplification <= GAIN_MAX)   // see (R18)
        else $error("gain above limit");
    uncapped_a: assert property ((cfg.cadence_source == CADENCE_LIMIT   // see (R16)
                                  && cfg.cadence_millihertz == ZERO_WORD && meas_req)
                                 |=> meas_tick)
        else $error("uncapped request not passed");
    tick_mode_a: assert property (!(cfg.cadence_source == CADENCE_SENSOR   // see (R15)
                                    || cfg.cadence_source == CADENCE_LIMIT)
                                  |=> !meas_tick)
        else $error("tick with no repetition mode");

endmodule : radar_host_regs

`default_nettype wire

// file: rtl/radar_regs_pkg.sv
// Purpose: Constants and types for the radar module host register bank
// Assumes: One 100 MHz clock; register requests already decoded from the serial link
// Notes:   Register addresses are word indices as seen by the host protocol
//
// Notes on behaviour
// (R01) Source active when pending and enabled
// (R02) Cleared enable bit blocks source; zero blocks all
// (R03) Bit 0 created, bit 1 activated
// (R04) Bit 8 new data ready
// (R05) Bits 16-19 error, command, mode, create-fail
// (R06) Mode zero holds interrupt pin inactive
// (R07) Mode one: pin active while enabled source active
// (R08) Read-only 16-bit part code; writes ignored
// (R09) Version packed major, minor, patch bytes
// (R10) Read-only highest supported baud rate
// (R11) Serial baud rate 115200 after reset
// (R12) Read-only count of waiting output data
// (R13) Writable config; metadata refreshed on create/data
// (R14) Range start and length in millimetres
// (R15) Mode one paces measurements precisely from rate
// (R16) Mode two caps rate; zero means uncapped
// (R17) Update rate counted in millihertz
// (R18) Gain accepted from 0 to 1000
// (R19) Power level codes off, sleep, ready, active
// (R20) Pending bits sticky, set even when disabled
// (R21) Host programs enables, services by clearing pending
package radar_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [7:0] ADDR_IRQ_PENDING  = 8'h06;
    localparam logic [7:0] ADDR_SERIAL_BAUD  = 8'h07;
    localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_PIN_SEL  = 8'h09;
    localparam logic [7:0] ADDR_MODULE_SLEEP = 8'h0A;
    localparam logic [7:0] ADDR_PART_CODE    = 8'h10;
    localparam logic [7:0] ADDR_FIRMWARE     = 8'h11;
    localparam logic [7:0] ADDR_TOP_SPEED    = 8'h12;
    localparam logic [7:0] ADDR_SWEEP_BEGIN  = 8'h20;
    localparam logic [7:0] ADDR_SWEEP_SPAN   = 8'h21;
    localparam logic [7:0] ADDR_CADENCE_SRC  = 8'h22;
    localparam logic [7:0] ADDR_CADENCE_MHZ  = 8'h23;
    localparam logic [7:0] ADDR_RX_AMP       = 8'h24;
    localparam logic [7:0] ADDR_CHIP_SLEEP   = 8'h25;
    localparam logic [7:0] ADDR_PENDING_OUT  = 8'hE9;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt bit positions and values
    localparam int BIT_CREATED     = 0;
    localparam int BIT_ACTIVATED   = 1;
    localparam int BIT_DATA_READY  = 8;
    localparam int BIT_ERROR       = 16;
    localparam int BIT_BAD_COMMAND = 17;
    localparam int BIT_BAD_MODE    = 18;
    localparam int BIT_CREATE_FAIL = 19;
    localparam logic [31:0] PIN_SEL_OFF    = 32'h0000_0000;
    localparam logic [31:0] PIN_SEL_ACTIVE = 32'h0000_0001;
    localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, limits and field positions
    localparam logic [31:0] DEFAULT_BAUD   = 32'h0001_C200;
    localparam logic [31:0] GAIN_MAX       = 32'h0000_03E8;
    localparam logic [31:0] CADENCE_SENSOR = 32'h0000_0001;
    localparam logic [31:0] CADENCE_LIMIT  = 32'h0000_0002;
    localparam int          POWER_W        = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Pacing: the accumulator wraps once per second of millihertz
    localparam longint      CLK_HZ      = 100_000_000;
    localparam longint      MHZ_PER_HZ  = 1_000;
    localparam int          PACE_W      = 40;
    localparam logic [39:0] PACE_WRAP   = 40'(CLK_HZ * MHZ_PER_HZ);

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {PWR_OFF, PWR_SLEEP, PWR_READY, PWR_ACTIVE} power_level_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [31:0] rdata;
    } reg_rsp_t;

    typedef struct packed {
        logic created;
        logic activated;
        logic data_ready;
        logic error;
        logic bad_command;
        logic bad_mode;
        logic create_fail;
    } events_t;

    typedef struct packed {
        logic [31:0]  sweep_begin_mm;
        logic [31:0]  sweep_span_mm;
        logic [31:0]  cadence_source;
        logic [31:0]  cadence_millihertz;
        logic [31:0]  rx_amplification;
        power_level_t radar_chip_sleep_level;
        logic [31:0]  module_sleep_config;
    } meas_cfg_t;

endpackage : radar_regs_pkg

// file: testbench/host_model.sv
// Purpose: Host side model that issues register requests and takes answers
// Assumes: Requests start just after a clock edge; answer stands one cycle later
// Notes:   After an access the idle request bus shows inverted values, never the last request
`timescale 1ns/1ns
`default_nettype none

module host_model
(
    input  wire logic                     clk_sys,
    input  wire radar_regs_pkg::reg_rsp_t rsp,
    output var  radar_regs_pkg::reg_req_t req
);
    import radar_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial req = '0;

    // One request pulse, answer taken at the following edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic [1:0] e);
        @(posedge clk_sys);
        #1 req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge clk_sys);
        #1 q = rsp.rdata;
        e = {rsp.valid, rsp.err};
        req = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    endtask : access
endmodule : host_model

`default_nettype wire

// file: testbench/tb.sv
// Purpose: Self-checking bench for the host register bank
// Assumes: Host model drives requests; bench drives events and levels
// Notes:   Pace rate chosen so that one tick falls every 100 cycles in mode one, every 101 in mode two
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); err_count++; end end

module tb;
    import radar_regs_pkg::*;
    localparam logic [15:0] PART = 16'h3C7E;    // Arbitrary value
    localparam logic [31:0] TOPB = 32'h000E_1000;
    localparam logic [31:0] RATE = 32'h3B9A_CA00;
    localparam logic [7:0]  CA [3] = '{ADDR_SWEEP_BEGIN, ADDR_SWEEP_SPAN, ADDR_CADENCE_MHZ};
    localparam logic [31:0] CV [3] = '{32'h0000_00C8, 32'h0000_0BB8, 32'h0000_1388};
    localparam int          IB [7] = '{BIT_CREATED, BIT_ACTIVATED, BIT_DATA_READY, BIT_ERROR,
                                       BIT_BAD_COMMAND, BIT_BAD_MODE, BIT_CREATE_FAIL};
    logic        clk_sys = 1'b0;
    logic        rst;
    reg_req_t    req;
    reg_rsp_t    rsp;
    events_t     evt;
    logic [31:0] buf_count;
    logic        meas_req;
    logic        host_int;
    logic        meas_tick;
    meas_cfg_t   cfg;
    logic [31:0] serial_baud;
    int          err_count = 0;
    int          comparisons = 0;
    int          n;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and host
    always #5 clk_sys = ~clk_sys;

    radar_host_regs #(.PART_CODE(PART), .FW_MAJOR(8'h02), .FW_MINOR(8'h05),
                      .FW_PATCH(8'h09), .TOP_BAUD(TOPB)) u_radar_host_regs (
        .clk_sys(clk_sys), .rst(rst), .req(req), .evt(evt), .buf_count(buf_count),
        .meas_req(meas_req), .rsp(rsp), .host_int(host_int), .meas_tick(meas_tick),
        .cfg(cfg), .serial_baud(serial_baud));

    host_model u_host_model (.clk_sys(clk_sys), .rsp(rsp), .req(req));

    ////////////////////////////////////////////////////////////////////////////////
    // Access and timing helpers
    task automatic cycles(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : cycles

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0]  e;
        u_host_model.access(1'b1, a, d, q, e);
        `CHK(e, 2'b10)
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] ex);
        logic [31:0] q;
        logic [1:0]  e;
        u_host_model.access(1'b0, a, 32'h0000_0000, q, e);
        `CHK(q, x)
        `CHK(e, ex)
    endtask : rd

    // Event pulse of one cycle, returns when the pin may have reacted
    task automatic pulse(input events_t v);
        @(posedge clk_sys);
        #1 evt = v;
        cycles(1);
        evt = '0;
        cycles(1);
    endtask : pulse

    task automatic wait_tick(output int k);
        k = 0;
        do
        begin
            cycles(1);
            k++;
        end
        while (meas_tick !== 1'b1 && k < 300);
    endtask : wait_tick

    task automatic tally_and_finish;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        #60000;
        err_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        rst = 1'b1;
        evt = '0;
        buf_count = 32'h0000_0000;
        meas_req = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 rst = 1'b0;
        `CHK(serial_baud, DEFAULT_BAUD)
        rd(ADDR_SERIAL_BAUD, DEFAULT_BAUD, 2'b10);
        rd(ADDR_IRQ_ENABLE, ZERO_WORD, 2'b10);
        wr(ADDR_PART_CODE, 32'hFFFF_FFFF);
        rd(ADDR_PART_CODE, {16'h0000, PART}, 2'b10);
        rd(ADDR_FIRMWARE, 32'h0002_0509, 2'b10);
        wr(ADDR_TOP_SPEED, ZERO_WORD);
        rd(ADDR_TOP_SPEED, TOPB, 2'b10);
        rd(8'h55, ZERO_WORD, 2'b11);
        $display("identity test done");
        for (int i = 0; i < 3; i++)
        begin
            wr(CA[i], CV[i]);
            rd(CA[i], CV[i], 2'b10);
        end
        `CHK(cfg.sweep_span_mm, CV[1])
        `CHK(cfg.cadence_millihertz, CV[2])
        wr(ADDR_RX_AMP, 32'h0000_01F4);
        rd(ADDR_RX_AMP, 32'h0000_01F4, 2'b10);
        wr(ADDR_RX_AMP, 32'h0000_03E9);
        rd(ADDR_RX_AMP, GAIN_MAX, 2'b10);
        wr(ADDR_MODULE_SLEEP, 32'h0000_0002);
        rd(ADDR_MODULE_SLEEP, 32'h0000_0002, 2'b10);
        `CHK(cfg.module_sleep_config, 32'h0000_0002)
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_CHIP_SLEEP, 32'(i));
            `CHK(cfg.radar_chip_sleep_level, power_level_t'(i))
        end
        $display("config test done");
        wr(ADDR_IRQ_PIN_SEL, PIN_SEL_ACTIVE);
        for (int i = 0; i < 7; i++)
        begin
            wr(ADDR_IRQ_ENABLE, 32'h1 << IB[i]);
            pulse(events_t'(7'h40 >> i));
            `CHK(host_int, 1'b1)
            rd(ADDR_IRQ_PENDING, 32'h1 << IB[i], 2'b10);
            wr(ADDR_IRQ_PENDING, 32'h1 << IB[i]);
            cycles(1);
            `CHK(host_int, 1'b0)
        end
        wr(ADDR_IRQ_ENABLE, ZERO_WORD);
        pulse(events_t'(7'h7F));
        `CHK(host_int, 1'b0)
        rd(ADDR_IRQ_PENDING, 32'h000F_0103, 2'b10);
        wr(ADDR_IRQ_PIN_SEL, PIN_SEL_OFF);
        wr(ADDR_IRQ_ENABLE, 32'h000F_0103);
        cycles(2);
        `CHK(host_int, 1'b0)
        wr(ADDR_IRQ_PIN_SEL, 32'h0000_0002);
        cycles(1);
        `CHK(host_int, 1'b0)
        wr(ADDR_IRQ_PIN_SEL, PIN_SEL_ACTIVE);
        cycles(1);
        `CHK(host_int, 1'b1)
        wr(ADDR_IRQ_PENDING, 32'h000F_0103);
        cycles(1);
        `CHK(host_int, 1'b0)
        $display("interrupt test done");
        buf_count = 32'h0000_0033;
        pulse(events_t'(7'h10));
        buf_count = 32'h0000_0044;
        rd(ADDR_PENDING_OUT, 32'h0000_0033, 2'b10);
        pulse(events_t'(7'h20));
        wr(ADDR_PENDING_OUT, 32'hFFFF_FFFF);
        rd(ADDR_PENDING_OUT, 32'h0000_0033, 2'b10);
        $display("metadata test done");
        wr(ADDR_CADENCE_MHZ, RATE);
        wr(ADDR_CADENCE_SRC, CADENCE_SENSOR);
        wait_tick(n);
        wait_tick(n);
        `CHK(n, 100)
        wr(ADDR_CADENCE_MHZ, ZERO_WORD);
        wr(ADDR_CADENCE_SRC, CADENCE_LIMIT);
        meas_req = 1'b1;
        cycles(1);
        `CHK(meas_tick, 1'b1)
        wr(ADDR_CADENCE_MHZ, RATE);
        wait_tick(n);
        wait_tick(n);
        `CHK(n >= 100 && n <= 102, 1'b1)
        meas_req = 1'b0;
        $display("pacing test done");
        wr(ADDR_SERIAL_BAUD, 32'h0003_8400);
        `CHK(serial_baud, 32'h0003_8400)
        rst = 1'b1;
        cycles(2);
        rst = 1'b0;
        `CHK(host_int, 1'b0)
        `CHK(serial_baud, DEFAULT_BAUD)
        `CHK(cfg.module_sleep_config, ZERO_WORD)
        `CHK(cfg.cadence_source, ZERO_WORD)
        rd(ADDR_IRQ_PENDING, ZERO_WORD, 2'b10);
        rd(ADDR_IRQ_PIN_SEL, PIN_SEL_OFF, 2'b10);
        rd(ADDR_SERIAL_BAUD, DEFAULT_BAUD, 2'b10);
        $display("reset test done");
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
